// ### src/ulaux_regs.vh
`ifndef ULAUX_REGS_VH
`define ULAUX_REGS_VH
// APB register byte offsets.
`define ULAUX_CTRL_OFF     12'h000
`define ULAUX_BAUD_OFF     12'h004
`define ULAUX_STAT_OFF     12'h008
`define ULAUX_GPIO_OFF     12'h00c
`define ULAUX_SUSP_OFF     12'h010
`define ULAUX_PERM_OFF     12'h014
// Control register fields.
`define ULAUX_CTRL_HDX     0
`define ULAUX_CTRL_IR      1
`define ULAUX_CTRL_IRINV   2
`define ULAUX_CTRL_IR4     3
`define ULAUX_CTRL_HIPWR   4
`define ULAUX_CTRL_USESUS  5
`define ULAUX_CTRL_DLY_LO  8
`define ULAUX_CTRL_S0_LO   12
`define ULAUX_CTRL_S1_LO   16
`define ULAUX_CTRL_CLKEN   20
`define ULAUX_CTRL_HDPIN   21
`define ULAUX_CTRL_RST     32'h0000_0000
// Status select codes for the two state pins.
`define ULAUX_SEL_SUSP     2'd0
`define ULAUX_SEL_LOWP     2'd1
`define ULAUX_SEL_BRST     2'd2
// Baud reset value: bit period in clocks, 16 sub-ticks per bit.
`define ULAUX_BAUD_RST     16'h0010
// Activity toggle: 10 Hz toggle means a half period of 50 ms.
`define ULAUX_ACT_MS       50
`define ULAUX_CLK_KHZ      20000
`define ULAUX_ACT_CYC      (`ULAUX_ACT_MS * `ULAUX_CLK_KHZ)
`endif

// ### src/ulaux_act_toggle.v
`timescale 1ns/1ns
`default_nettype none
// Activity toggle: flips every HALF cycles while the line shows activity.
module ulaux_act_toggle #(
  parameter HALF = 1000000
) (
  input  wire pclk,     // Clock.
  input  wire presetn,  // Async reset, active low.
  input  wire line,     // Serial line, idle high.
  output reg  tog_q     // Toggle output.
);
  reg [31:0] cnt_q;
  reg [31:0] idle_q;
  wire       active = (idle_q != 32'h0);

  // Activity lasts one half period after the last low bit seen.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 32'h0;
      idle_q <= 32'h0;
      tog_q  <= 1'b0;
    end else begin
      if (!line)
        idle_q <= HALF;
      else if (active)
        idle_q <= idle_q - 32'h1;
      if (active && cnt_q >= HALF - 1) begin
        cnt_q <= 32'h0;
        tog_q <= ~tog_q;
      end else if (active)
        cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule // ulaux_act_toggle
`default_nettype wire

// ### src/ulaux_ir_shaper.v
`timescale 1ns/1ns
`default_nettype none
// Infrared pulse shaper: a centred pulse of 3 or 4 sixteenths for each zero bit.
module ulaux_ir_shaper (
  input  wire        pclk,     // Clock.
  input  wire        presetn,  // Async reset, active low.
  input  wire        bit_start,// Pulse at start of each bit period.
  input  wire        tick16,   // Sixteenth-of-bit tick.
  input  wire        txd,      // Transmit data bit.
  input  wire        wide,     // 1: four sixteenths, 0: three.
  output reg         pulse_q   // Shaped infrared output.
);
  reg [3:0] ph_q;
  reg       zero_q;

  // Phase counts sixteenths; pulse sits around the midpoint of the bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q    <= 4'h0;
      zero_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      if (bit_start) begin
        ph_q   <= 4'h0;
        zero_q <= ~txd;
      end else if (tick16)
        ph_q <= ph_q + 4'h1;
      pulse_q <= zero_q && (wide ? (ph_q >= 4'd6 && ph_q <= 4'd9)
                                 : (ph_q >= 4'd7 && ph_q <= 4'd9));
    end
  end
endmodule // ulaux_ir_shaper
`default_nettype wire

// ### src/ulaux_top.v
// Function
// - With zero delay, transmit enable drops right after the last stop bit.
// - Enable release may be postponed 1 to 15 bit periods.
// - In half-duplex, receive input is ignored while transmitting.
// - Infrared pulses are 3/16 or 4/16 bit, centred, up to 1.25 Mbaud.
// - Infrared receive data may be inverted before decoding.
// - Infrared mode is off after reset, on only by its report.
// - Two state pins, each selects one of three indications, either polarity.
// - Suspend indication active while host holds device suspended.
// - Low-power active in suspend, and before configuration for high-power devices.
// - For low-power devices, low-power indication equals suspend indication.
// - Bus-reset indication active while host signals reset.
// - Override clear: GPIO outputs hold their levels during suspend.
// - Override set: GPIO take suspend level and drive type on suspend.
// - Override set: clock pin forced low, half-duplex enable forced inactive.
// - Volatile suspend settings clear on bus reset; permanent ones persist.
// - Activity outputs toggle near 10 Hz while line active, else still.
`timescale 1ns/1ns
`default_nettype none
`include "ulaux_regs.vh"
module ulaux_top #(
  parameter NGPIO    = 10,
  parameter ACT_HALF = `ULAUX_ACT_CYC
) (
  input  wire             pclk,          // APB clock, 20 MHz.
  input  wire             presetn,       // Async reset, active low.
  input  wire             psel,          // APB select.
  input  wire             penable,       // APB enable.
  input  wire             pwrite,        // APB direction.
  input  wire [11:0]      paddr,         // APB byte address.
  input  wire [31:0]      pwdata,        // APB write data.
  output wire [31:0]      prdata,        // APB read data.
  output wire             pready,        // APB ready.
  output wire             pslverr,       // APB error on unmapped address.
  input  wire             tx_busy,       // Transmitter shifting a frame.
  input  wire             tx_load,       // New transmit byte accepted.
  input  wire             txd,           // Serial transmit data.
  input  wire             rxd_pin,       // Raw receive pin.
  output wire             rxd_core,      // Receive data to the receiver.
  output wire             txd_pin,       // Transmit pin (UART or infrared).
  output wire             hdx_en,        // Half-duplex transmit enable, active high.
  input  wire             usb_suspend,   // Host holds device suspended.
  input  wire             usb_configured,// Host has configured device.
  input  wire             usb_reset,     // Host signals bus reset.
  input  wire             clk_gen,       // Generated clock for clock pin.
  input  wire [NGPIO-1:0] gpio_o,        // Normal GPIO output levels.
  input  wire [NGPIO-1:0] gpio_od,       // Normal GPIO open-drain select.
  output reg  [NGPIO-1:0] pin_o,         // GPIO pin output level.
  output reg  [NGPIO-1:0] pin_oe_n,      // GPIO output enable, low drives.
  output wire [1:0]       usb_stat,      // USB state pins.
  output wire             transmit_activity_toggle, // Transmit activity.
  output wire             receive_activity_toggle   // Receive activity.
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0]      ctrl_q;
  reg [15:0]      baud_q;
  reg [31:0]      susp_q;   // Volatile: [9:0] level, [25:16] open drain, [31] valid.
  reg [31:0]      perm_q;   // Permanent pin settings, same layout.
  reg [NGPIO-1:0] hold_o_q;
  reg [NGPIO-1:0] hold_od_q;
  reg             susp_d1_q;
  reg [31:0]      rdata_q;

  wire wr = psel && penable && pwrite;
  wire rd_hit = (paddr == `ULAUX_CTRL_OFF) || (paddr == `ULAUX_BAUD_OFF) ||
                (paddr == `ULAUX_STAT_OFF) || (paddr == `ULAUX_GPIO_OFF) ||
                (paddr == `ULAUX_SUSP_OFF) || (paddr == `ULAUX_PERM_OFF);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  assign prdata  = rdata_q;

  wire       hdx_mode = ctrl_q[`ULAUX_CTRL_HDX];
  wire       ir_on    = ctrl_q[`ULAUX_CTRL_IR];
  wire       ir_inv   = ctrl_q[`ULAUX_CTRL_IRINV];
  wire       ir_wide  = ctrl_q[`ULAUX_CTRL_IR4];
  wire       hi_pwr   = ctrl_q[`ULAUX_CTRL_HIPWR];
  wire       use_sus  = ctrl_q[`ULAUX_CTRL_USESUS];
  wire [3:0] dly_cfg  = ctrl_q[`ULAUX_CTRL_DLY_LO+3:`ULAUX_CTRL_DLY_LO];
  wire       clk_en   = ctrl_q[`ULAUX_CTRL_CLKEN];
  wire       hd_pin   = ctrl_q[`ULAUX_CTRL_HDPIN];

  // Register writes; the control word carries the infrared and delay reports.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ULAUX_CTRL_RST;
      baud_q <= `ULAUX_BAUD_RST;
      susp_q <= 32'h0;
      perm_q <= 32'h0;
    end else begin
      if (wr && paddr == `ULAUX_CTRL_OFF)
        ctrl_q <= pwdata;
      if (wr && paddr == `ULAUX_BAUD_OFF)
        baud_q <= (pwdata[15:0] < 16'h0010) ? 16'h0010 : pwdata[15:0];
      if (usb_reset)
        susp_q <= 32'h0;
      else if (wr && paddr == `ULAUX_SUSP_OFF)
        susp_q <= pwdata;
      if (wr && paddr == `ULAUX_PERM_OFF)
        perm_q <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Sixteen sub-ticks per bit; the bit period follows the baud register.
  reg [15:0] sub_q;
  reg [3:0]  six_q;
  wire [11:0] sub_len = baud_q[15:4];
  wire tick16 = (sub_q[11:0] >= sub_len - 12'h1);
  wire bit_end = tick16 && (six_q == 4'hf);
  reg  tx_busy_d_q;
  wire tx_start = tx_busy && !tx_busy_d_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_q       <= 16'h0;
      six_q       <= 4'h0;
      tx_busy_d_q <= 1'b0;
    end else begin
      tx_busy_d_q <= tx_busy;
      if (tx_start) begin
        sub_q <= 16'h0;
        six_q <= 4'h0;
      end else if (tick16) begin
        sub_q <= 16'h0;
        six_q <= six_q + 4'h1;
      end else
        sub_q <= sub_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Turn-around delay
  // ----------------------------------------------------------------
  // The counter loads when the last stop bit ends and counts bit periods.
  reg [3:0] dly_q;
  reg       hold_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q  <= 4'h0;
      hold_q <= 1'b0;
    end else if (tx_busy || tx_load) begin
      hold_q <= 1'b0;
      dly_q  <= 4'h0;
    end else if (tx_busy_d_q && dly_cfg != 4'h0) begin
      hold_q <= 1'b1;
      dly_q  <= dly_cfg;
    end else if (hold_q && bit_end) begin
      if (dly_q == 4'h1)
        hold_q <= 1'b0;
      dly_q <= dly_q - 4'h1;
    end
  end

  // The load cycle and the last bit of the hold are covered combinationally, so the enable
  // neither dips for a cycle when the frame ends nor stays one cycle past the delay.
  wire hold_end = hold_q && bit_end && (dly_q == 4'h1);
  wire hold_ld  = tx_busy_d_q && !tx_busy && (dly_cfg != 4'h0);
  wire en_raw   = tx_busy || hold_ld || (hold_q && !hold_end);
  assign hdx_en = en_raw && !(use_sus && usb_suspend);

  // ----------------------------------------------------------------
  // Receive path and infrared
  // ----------------------------------------------------------------
  wire rx_in = ir_on && ir_inv ? ~rxd_pin : rxd_pin;
  assign rxd_core = (hdx_mode && tx_busy) ? 1'b1 : rx_in;

  wire ir_pulse;
  ulaux_ir_shaper u_ir (
    .pclk      (pclk),
    .presetn   (presetn),
    .bit_start (tx_start || bit_end),
    .tick16    (tick16),
    .txd       (txd),
    .wide      (ir_wide),
    .pulse_q   (ir_pulse)
  );
  assign txd_pin = ir_on ? ir_pulse : txd;

  // ----------------------------------------------------------------
  // USB state pins
  // ----------------------------------------------------------------
  wire st_susp = usb_suspend;
  wire st_lowp = usb_suspend || (hi_pwr && !usb_configured);
  wire st_brst = usb_reset;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_stat
      wire [1:0] sel = ctrl_q[`ULAUX_CTRL_S0_LO+4*gi+1:`ULAUX_CTRL_S0_LO+4*gi];
      wire       pol = ctrl_q[`ULAUX_CTRL_S0_LO+4*gi+2];
      wire       st  = (sel == `ULAUX_SEL_SUSP) ? st_susp :
                       (sel == `ULAUX_SEL_LOWP) ? st_lowp :
                       (sel == `ULAUX_SEL_BRST) ? st_brst : 1'b0;
      assign usb_stat[gi] = st ^ pol;
    end
  endgenerate

  // ----------------------------------------------------------------
  // GPIO suspend behaviour
  // ----------------------------------------------------------------
  // Levels are captured on entry to suspend so they stay put throughout.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_d1_q <= 1'b0;
      hold_o_q  <= {NGPIO{1'b0}};
      hold_od_q <= {NGPIO{1'b0}};
    end else begin
      susp_d1_q <= usb_suspend;
      if (usb_suspend && !susp_d1_q) begin
        hold_o_q  <= gpio_o;
        hold_od_q <= gpio_od;
      end
    end
  end

  wire [31:0] sus_cfg = susp_q[31] ? susp_q : perm_q;
  wire        suspended = usb_suspend && susp_d1_q;

  // Pin 0 may be the clock, pin 3 or, by its select, pin 1 the half-duplex enable.
  integer k;
  always @* begin
    for (k = 0; k < NGPIO; k = k + 1) begin
      pin_o[k]    = gpio_o[k];
      pin_oe_n[k] = gpio_od[k] & gpio_o[k];
      if (k == 0 && clk_en)
        pin_o[k] = clk_gen;
      if ((k == 3 && !hd_pin) || (k == 1 && hd_pin)) begin
        pin_o[k]    = hdx_en;
        pin_oe_n[k] = 1'b0;
      end
      if (suspended && !use_sus) begin
        pin_o[k]    = hold_o_q[k];
        pin_oe_n[k] = hold_od_q[k] & hold_o_q[k];
      end else if (suspended) begin
        pin_o[k]    = sus_cfg[k];
        pin_oe_n[k] = sus_cfg[16+k] & sus_cfg[k];
        if (k == 0 && clk_en) begin
          pin_o[k]    = 1'b0;
          pin_oe_n[k] = 1'b0;
        end
        if ((k == 3 && !hd_pin) || (k == 1 && hd_pin)) begin
          pin_o[k]    = 1'b0;
          pin_oe_n[k] = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity toggles and readback
  // ----------------------------------------------------------------
  ulaux_act_toggle #(.HALF(ACT_HALF)) u_txt (
    .pclk    (pclk),
    .presetn (presetn),
    .line    (txd),
    .tog_q   (transmit_activity_toggle)
  );
  ulaux_act_toggle #(.HALF(ACT_HALF)) u_rxt (
    .pclk    (pclk),
    .presetn (presetn),
    .line    (rxd_pin),
    .tog_q   (receive_activity_toggle)
  );

  // Read data registered in the setup cycle so it is stable at access.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rdata_q <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ULAUX_CTRL_OFF: rdata_q <= ctrl_q;
        `ULAUX_BAUD_OFF: rdata_q <= {16'h0, baud_q};
        `ULAUX_STAT_OFF: rdata_q <= {24'h0, dly_q, hdx_en, usb_reset,
                                      usb_configured, usb_suspend};
        `ULAUX_GPIO_OFF: rdata_q <= {{(32-NGPIO){1'b0}}, pin_o};
        `ULAUX_SUSP_OFF: rdata_q <= susp_q;
        `ULAUX_PERM_OFF: rdata_q <= perm_q;
        default:         rdata_q <= 32'h0;
      endcase
    end
  end
endmodule // ulaux_top
`default_nettype wire

// ### tb/ulaux_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Port checker for the line aux block
// ---------------------------------------------------------------
module ulaux_asserts #(
  parameter ACT_HALF = 20
) (
  input wire logic        pclk,           // Clock.
  input wire logic        presetn,        // Reset, active low.
  input wire logic        psel,           // Select.
  input wire logic        penable,        // Enable.
  input wire logic        pwrite,         // Direction.
  input wire logic [11:0] paddr,          // Address.
  input wire logic [31:0] pwdata,         // Write data.
  input wire logic        pready,         // Ready.
  input wire logic        pslverr,        // Error.
  input wire logic        tx_busy,        // Frame in flight.
  input wire logic        txd,            // Transmit data.
  input wire logic        rxd_pin,        // Raw receive.
  input wire logic        rxd_core,       // Receive to core.
  input wire logic        txd_pin,        // Transmit pin.
  input wire logic        hdx_en,         // Turn-around enable.
  input wire logic        usb_suspend,    // Suspended.
  input wire logic        usb_configured, // Configured.
  input wire logic        usb_reset,      // Bus reset.
  input wire logic [1:0]  usb_stat,       // State pins.
  input wire logic        transmit_activity_toggle // Activity.
);
  logic [31:0] ctrl_q, baud_q;
  int          hcnt_q, icnt_q;
  // Shadow the control and baud words, since the checker cannot see inside.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0;
      baud_q <= 32'h10;
      hcnt_q <= 0;
      icnt_q <= 0;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h000)
        ctrl_q <= pwdata;
      if (psel && penable && pwrite && paddr == 12'h004)
        baud_q <= pwdata;
      hcnt_q <= (hdx_en && !tx_busy) ? hcnt_q + 1 : 0;
      icnt_q <= txd ? ((icnt_q < 1000) ? icnt_q + 1 : icnt_q) : 0;
    end
  end
  // Expected level of one state pin from its select and polarity.
  function automatic logic ind(input logic [2:0] s);
    logic v;
    case (s[1:0])
      2'd0: v = usb_suspend;
      2'd1: v = usb_suspend || (ctrl_q[4] && !usb_configured);
      2'd2: v = usb_reset;
      default: v = 1'b0;
    endcase
    return v ^ s[2];
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high:
    assert property (psel && penable |-> pready) else $error("ready low");
  chk_err_unmapped:
    assert property (psel && penable && paddr > 12'h014 |-> pslverr) else $error("no error");
  chk_rx_blank:
    assert property (ctrl_q[0] && tx_busy |-> rxd_core) else $error("rx not blanked");
  chk_rx_path:
    assert property (!(ctrl_q[0] && tx_busy) |-> rxd_core == (rxd_pin ^ (ctrl_q[1] && ctrl_q[2])))
      else $error("rx path wrong");
  chk_tx_plain:
    assert property (!ctrl_q[1] |-> txd_pin == txd) else $error("tx not plain");
  chk_stat_pins:
    assert property (usb_stat == {ind(ctrl_q[18:16]), ind(ctrl_q[14:12])})
      else $error("state pins wrong");
  chk_hold_zero:
    assert property (!tx_busy && ctrl_q[11:8] == 4'h0 |-> !hdx_en) else $error("enable held");
  chk_hold_len:
    assert property ($fell(hdx_en) && !tx_busy && !usb_suspend
      |-> hcnt_q == ctrl_q[11:8] * baud_q[15:0]) else $error("hold length wrong");
  chk_act_still:
    assert property (icnt_q > ACT_HALF + 2 |-> $stable(transmit_activity_toggle))
      else $error("idle toggle moved");
endmodule // ulaux_asserts

bind ulaux_top ulaux_asserts #(.ACT_HALF(ACT_HALF)) u_ulaux_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .tx_busy(tx_busy), .txd(txd), .rxd_pin(rxd_pin), .rxd_core(rxd_core),
  .txd_pin(txd_pin), .hdx_en(hdx_en), .usb_suspend(usb_suspend),
  .usb_configured(usb_configured), .usb_reset(usb_reset), .usb_stat(usb_stat),
  .transmit_activity_toggle(transmit_activity_toggle));
`default_nettype wire

// ### tb/ulaux_far_end.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Remote UART driving the receive line
// ---------------------------------------------------------------
module ulaux_far_end #(
  parameter int BIT = 16
) (
  input  wire logic       pclk,   // Clock.
  input  wire logic       go,     // Start one frame.
  input  wire logic [7:0] data,   // Byte to send.
  output var  logic       rxd_pin // Line to the device.
);
  logic [9:0] sh_q = 10'h3ff;
  int         cnt_q = 0;
  // Start bit, data low bit first, stop bit; the line rests high when idle.
  always @(posedge pclk) begin
    if (go && cnt_q == 0) begin
      sh_q <= {1'b1, data, 1'b0};
      cnt_q <= 10 * BIT;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q % BIT == 1)
        sh_q <= {1'b1, sh_q[9:1]};
    end
  end
  assign rxd_pin = sh_q[0];
endmodule // ulaux_far_end
`default_nettype wire

// ### tb/uart_line_aux_and_usb_status_test.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench
// ---------------------------------------------------------------
module uart_line_aux_and_usb_status_test;
  localparam int BIT = 16;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 32'h8addceb0;
  logic        pready, pslverr, rxd_core, txd_pin, hdx_en, far_go = 0, pt, pr;
  logic        tx_busy = 0, tx_load = 0, txd = 1, clk_gen = 0;
  logic        usb_suspend = 0, usb_configured = 0, usb_reset = 0;
  logic [9:0]  gpio_o = 0, gpio_od = 0, pin_o, pin_oe_n, gv;
  logic [7:0]  far_data = 0;
  logic [1:0]  usb_stat;
  logic        transmit_activity_toggle, receive_activity_toggle;
  wire         rxd_pin;
  logic [31:0] exp_q[$];
  int          bad_count = 0, check_count = 0, cyc = 0, n, m, dl[3] = '{0, 1, 15};
  ulaux_top #(.ACT_HALF(20)) u_ulaux_top (.*);
  ulaux_far_end #(.BIT(BIT)) u_ulaux_far_end (.pclk(pclk), .go(far_go), .data(far_data),
    .rxd_pin(rxd_pin));
  // Clock, a free generated clock, and a hang limit well above the run length.
  always #25 pclk = ~pclk;
  always @(posedge pclk) clk_gen <= ~clk_gen;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end
  // Each completed read is judged against the oldest noted expectation.
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check("prdata", prdata, exp_q.pop_front());
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // The idle edge in front keeps two transfers from touching psel in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask
  task automatic frame(input int nb);
    @(posedge pclk);
    tx_busy <= 1;
    tx_load <= 1;
    far_go <= 1;
    far_data <= seed[15:8];
    for (int i = 0; i < nb * BIT; i++) begin
      if (i % BIT == 0)
        seed = nxt(seed);
      txd <= seed[0];
      @(posedge pclk);
      tx_load <= 0;
      far_go <= 0;
    end
    tx_busy <= 0;
    txd <= 1;
  endtask
  task automatic susp_rd(input logic [31:0] e);
    @(posedge pclk);
    usb_suspend <= 1;
    repeat (3) @(posedge pclk);
    gpio_o <= ~gpio_o;
    rd(12'h00c, e);
    usb_suspend <= 0;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 0);
    rd(12'h004, 32'h10);
    rd(12'h010, 0);
    rd(12'h020, 0);
    foreach (dl[i]) begin
      apb(1, 12'h000, 32'h1 | (dl[i] << 8));
      frame(3);
      repeat (5) @(posedge pclk);
      frame(2);
      n = 0;
      #1;
      while (hdx_en === 1'b1 && n < 400) begin
        @(posedge pclk);
        #1;
        n++;
      end
      check("hold", n, dl[i] * BIT);
    end
    apb(1, 12'h004, 32'h40);
    for (int w = 0; w < 2; w++) begin
      apb(1, 12'h000, 32'h6 | (w << 3));
      @(posedge pclk);
      tx_busy <= 1;
      txd <= 0;
      far_go <= 1;
      n = 0;
      repeat (64) begin
        @(posedge pclk);
        far_go <= 0;
        #1;
        n += (txd_pin === 1'b1);
      end
      @(posedge pclk);
      tx_busy <= 0;
      txd <= 1;
      check("ir pulse", n, (3 + w) * 4);
    end
    for (int s = 0; s < 8; s++) begin
      apb(1, 12'h000, (s << 12) | ((s ^ 3) << 16) | ((s & 1) << 4));
      for (int c = 0; c < 8; c++) begin
        @(posedge pclk);
        {usb_reset, usb_configured, usb_suspend} <= c[2:0];
        rd(12'h008, c);
      end
    end
    {usb_reset, usb_configured, usb_suspend} <= 3'h0;
    apb(1, 12'h000, 0);
    seed = nxt(seed);
    gv = seed[9:0];
    gpio_o <= gv;
    susp_rd({22'h0, gv});
    apb(1, 12'h014, 32'h155);
    apb(1, 12'h010, 32'h8000_02a5);
    apb(1, 12'h000, 32'h0010_0020);
    susp_rd(32'h2a4);
    @(posedge pclk);
    usb_reset <= 1;
    @(posedge pclk);
    usb_reset <= 0;
    rd(12'h010, 0);
    rd(12'h014, 32'h155);
    susp_rd(32'h154);
    @(posedge pclk);
    txd <= 0;
    far_go <= 1;
    far_data <= 8'h00;
    n = 0;
    m = 0;
    #1;
    pt = transmit_activity_toggle;
    pr = receive_activity_toggle;
    repeat (140) begin
      @(posedge pclk);
      far_go <= 0;
      #1;
      n += (transmit_activity_toggle !== pt);
      m += (receive_activity_toggle !== pr);
      pt = transmit_activity_toggle;
      pr = receive_activity_toggle;
    end
    @(posedge pclk);
    txd <= 1;
    check("tx activity", n >= 5 && n <= 8, 1);
    check("rx activity", m >= 5 && m <= 8, 1);
    repeat (80) @(posedge pclk);
    test_done();
  end
endmodule // uart_line_aux_and_usb_status_test
`default_nettype wire
